// ===== rtl/card_detect_threshold_regs.v
// threshold, result and option registers of the low-power card detection
// assumes the measurement sequencer runs on aclk and pulses its strobes for one cycle
`timescale 1ns/1ps
`include "card_detect_map.vh"

module card_detect_threshold_regs #(
    parameter NEWER_VARIANT = 1
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // measurement sequencer
    input wire meas_start,
    input wire meas_done,
    input wire [5:0] meas_i,
    input wire [5:0] meas_q,
    input wire i_changed,
    input wire q_changed,
    // detection controls and status
    output reg detect_irq_flag,
    output reg full_drive_during_detect,
    output reg noise_filter_enable,
    output reg sample_time_up
);

////////////////////////////////////////////////////////////////////////////////
// register state
reg [5:0] i_upper_threshold_q;
reg [5:0] q_upper_threshold_q;
reg [5:0] i_lower_threshold_q;
reg [5:0] q_lower_threshold_q;
reg [5:0] i_measurement_result_q;
reg [5:0] q_measurement_result_q;
reg detect_irq_suppress_q;
reg i_value_unstable_q;
reg q_value_unstable_q;
reg sampling_q;
reg [`CNT_W-1:0] sample_cnt_q;

// write channel latches
reg aw_got_q;
reg w_got_q;
reg [`ADDR_W-1:0] awaddr_q;
reg [7:0] wbyte_q;
reg wlane_q;

////////////////////////////////////////////////////////////////////////////////
// address decode helpers
wire [7:0] wr_idx;
wire [7:0] rd_idx;
wire wr_fire;
wire wr_en;
wire opt_present;

assign wr_idx = awaddr_q[`ADDR_W-1:2];
assign rd_idx = s_axi_araddr[`ADDR_W-1:2];
assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
assign wr_en = wr_fire && wlane_q;
assign opt_present = (NEWER_VARIANT != 0);

// mapped check for an index
function mapped;
    input [7:0] idx;
    begin
        mapped = (idx == `IDX_DETECT_OPTIONS) || (idx == `IDX_Q_LOWER) ||
                 (idx == `IDX_Q_UPPER) || (idx == `IDX_I_LOWER) ||
                 (idx == `IDX_I_RESULT) || (idx == `IDX_Q_RESULT);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// write address and data capture, either order
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        awaddr_q <= {`ADDR_W{1'b0}};
        wbyte_q <= `RST_BYTE;
        wlane_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_got_q <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_got_q <= 1'b0;
        end
        // ready one cycle per taken item
        s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
        s_axi_wready <= !w_got_q && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
    end
end

////////////////////////////////////////////////////////////////////////////////
// write response
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// threshold and option registers
always @(posedge aclk) begin
    if (!aresetn) begin
        i_upper_threshold_q <= `RST_BORDER;
        q_upper_threshold_q <= `RST_BORDER;
        i_lower_threshold_q <= `RST_BORDER;
        q_lower_threshold_q <= `RST_BORDER;
        full_drive_during_detect <= 1'b0;
        noise_filter_enable <= 1'b0;
    end else if (wr_en) begin
        case (wr_idx)
            `IDX_Q_LOWER: begin
                i_upper_threshold_q[5:4] <= wbyte_q[`SPLIT_HI:`SPLIT_LO];
                q_lower_threshold_q <= wbyte_q[`BORDER_HI:0];
            end
            `IDX_Q_UPPER: begin
                i_upper_threshold_q[3:2] <= wbyte_q[`SPLIT_HI:`SPLIT_LO];
                q_upper_threshold_q <= wbyte_q[`BORDER_HI:0];
            end
            `IDX_I_LOWER: begin
                i_upper_threshold_q[1:0] <= wbyte_q[`SPLIT_HI:`SPLIT_LO];
                i_lower_threshold_q <= wbyte_q[`BORDER_HI:0];
            end
            `IDX_DETECT_OPTIONS: begin
                if (opt_present) begin
                    full_drive_during_detect <= wbyte_q[`OPT_FULL_DRIVE];
                    noise_filter_enable <= wbyte_q[`OPT_FILTER];
                end
            end
            default: begin
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// suppress bit: a Q result write sets it with bit 6 high and clears it with bit 6 low, next procedure start clears, set wins
always @(posedge aclk) begin
    if (!aresetn) begin
        detect_irq_suppress_q <= 1'b0;
    end else if (wr_en && wr_idx == `IDX_Q_RESULT && wbyte_q[`SUPPRESS_BIT]) begin
        detect_irq_suppress_q <= 1'b1;
    end else if (wr_en && wr_idx == `IDX_Q_RESULT) begin
        detect_irq_suppress_q <= 1'b0;
    end else if (meas_start) begin
        detect_irq_suppress_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// result capture and border comparison
wire outside;
wire suppress_now;

assign outside = (meas_i > i_upper_threshold_q) ||
                 (meas_q > q_upper_threshold_q) ||
                 (meas_i < i_lower_threshold_q) ||
                 (meas_q < q_lower_threshold_q);
assign suppress_now = detect_irq_suppress_q ||
                      (wr_en && wr_idx == `IDX_Q_RESULT && wbyte_q[`SUPPRESS_BIT]);

always @(posedge aclk) begin
    if (!aresetn) begin
        i_measurement_result_q <= `RST_BORDER;
        q_measurement_result_q <= `RST_BORDER;
        i_value_unstable_q <= 1'b0;
        q_value_unstable_q <= 1'b0;
        detect_irq_flag <= 1'b0;
    end else begin
        if (meas_done) begin
            i_measurement_result_q <= meas_i;
            q_measurement_result_q <= meas_q;
            q_value_unstable_q <= noise_filter_enable && q_changed;
            i_value_unstable_q <= noise_filter_enable && i_changed;
        end
        // suppress clear wins over flag set
        if (meas_done && outside && !suppress_now) begin
            detect_irq_flag <= 1'b1;
        end else if (suppress_now) begin
            detect_irq_flag <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// sampling window limit on every procedure, whether or not the filter is on
always @(posedge aclk) begin
    if (!aresetn) begin
        sampling_q <= 1'b0;
        sample_cnt_q <= {`CNT_W{1'b0}};
        sample_time_up <= 1'b0;
    end else begin
        if (meas_start) begin
            sampling_q <= 1'b1;
            sample_cnt_q <= {`CNT_W{1'b0}};
        end else if (meas_done || sample_time_up) begin
            sampling_q <= 1'b0;
        end else if (sampling_q) begin
            sample_cnt_q <= sample_cnt_q + 1'b1;
        end
        // one-cycle pulse when the window closes
        sample_time_up <= sampling_q && !meas_start && !meas_done && !sample_time_up &&
                          (sample_cnt_q == `SAMPLE_CYCLES - 2);
    end
end

////////////////////////////////////////////////////////////////////////////////
// read channel
reg [7:0] rd_byte;

// read mux
always @* begin
    rd_byte = `RST_BYTE;
    case (rd_idx)
        `IDX_Q_LOWER: rd_byte = {i_upper_threshold_q[5:4], q_lower_threshold_q};
        `IDX_Q_UPPER: rd_byte = {i_upper_threshold_q[3:2], q_upper_threshold_q};
        `IDX_I_LOWER: rd_byte = {i_upper_threshold_q[1:0], i_lower_threshold_q};
        `IDX_I_RESULT: rd_byte = {2'h0, i_measurement_result_q};
        `IDX_Q_RESULT: rd_byte = {1'b0, detect_irq_suppress_q, q_measurement_result_q};
        `IDX_DETECT_OPTIONS: begin
            if (opt_present) begin
                rd_byte = {4'h0, full_drive_during_detect, noise_filter_enable,
                           q_value_unstable_q, i_value_unstable_q};
            end
        end
        default: rd_byte = `RST_BYTE;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RESP_OKAY;
    end else begin
        s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule

// ===== rtl/card_detect_map.vh
// register map, field positions and timing constants of the card detection registers
// assumes a 10 MHz clock and 32-bit AXI4-Lite words, register index times four
// Notes on behaviour
// - Q upper threshold bits 7 and 6 carry bits 3 and 2 of the I upper threshold.
// - I lower threshold bits 7 and 6 carry bits 1 and 0 of the I upper threshold.
// - An I result above the assembled I upper threshold raises the detection interrupt.
// - Q upper threshold bits 5 to 0 are a border, and a Q result above it raises the interrupt.
// - I lower threshold bits 5 to 0 are a border, and an I result below it raises the interrupt.
// - The I result register shows the last I value in bits 5 to 0, read only, bits 7 and 6 zero.
// - The Q result register shows the last Q value in bits 5 to 0, read only.
// - Setting Q result bit 6 stops further detection interrupts until the next procedure starts; here a Q result write with bit 6 clear also ends it.
// - The options register exists on the newer variant only, else its address is reserved; the older variant here answers OKAY there, not SLVERR.
// - Option bit 3 selects full transmitter supply during detection, else supply minus 0.4V.
// - Option bit 2 bases the decision on filtered samples, sampling at most 4.72us.
// - Read-only option bit 1 reports a Q converter change during measuring, filter on only.
// - Read-only option bit 0 reports an I converter change during measuring, filter on only.
// - Q lower threshold bits 7 and 6 carry bits 5 and 4 of the I upper threshold.
// - Q lower threshold bits 5 to 0 are a border, and a Q result below it raises the interrupt.
`ifndef CARD_DETECT_MAP_VH
`define CARD_DETECT_MAP_VH

// register indices, byte address is index times four
`define IDX_DETECT_OPTIONS 8'h3a
`define IDX_Q_LOWER 8'h3f
`define IDX_Q_UPPER 8'h40
`define IDX_I_LOWER 8'h41
`define IDX_I_RESULT 8'h42
`define IDX_Q_RESULT 8'h43
`define ADDR_W 10

// field positions
`define BORDER_HI 5
`define SPLIT_HI 7
`define SPLIT_LO 6
`define SUPPRESS_BIT 6
`define OPT_FULL_DRIVE 3
`define OPT_FILTER 2
`define OPT_Q_UNSTABLE 1
`define OPT_I_UNSTABLE 0

// reset values
`define RST_BYTE 8'h00
`define RST_BORDER 6'h00

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// sampling window
`define CLK_PERIOD_NS 100
`define SAMPLE_TIME_NS 4720
`define SAMPLE_CYCLES (`SAMPLE_TIME_NS / `CLK_PERIOD_NS)
`define CNT_W 6

`endif

// ===== verif/card_detect_regs_monitor.sv
// checker for the card detection register block
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ps
module card_detect_regs_monitor (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // bus handshakes
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // measurement and status
    input wire meas_start,
    input wire meas_done,
    input wire detect_irq_flag,
    input wire noise_filter_enable,
    input wire full_drive_during_detect,
    input wire sample_time_up
);
    logic [7:0] run_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    // cycles since the procedure began
    always @(posedge aclk) begin
        if (!aresetn || meas_done) run_q <= 8'h00;
        else if (meas_start) run_q <= 8'h01;
        else if (run_q != 8'h00 && run_q != 8'hff) run_q <= run_q + 8'h01;
    end
    ////////////////////////////////////////
    a_flag_after_done: assert property ($rose(detect_irq_flag) |-> $past(meas_done))
        else $error("flag rose without a measurement");
    a_flag_clear_write: assert property ($fell(detect_irq_flag) |-> ##[0:2] s_axi_bvalid)
        else $error("flag fell without a write");
    a_filter_by_write: assert property ($changed(noise_filter_enable) |-> ##[0:2] s_axi_bvalid)
        else $error("filter option moved without a write");
    a_drive_by_write: assert property ($changed(full_drive_during_detect) |-> ##[0:2] s_axi_bvalid)
        else $error("drive option moved without a write");
    a_window_bound: assert property (sample_time_up |-> run_q >= 8'd46 && run_q <= 8'd49)
        else $error("sampling window length wrong");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_read_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read upper bits set");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    c_flag: cover property ($rose(detect_irq_flag));
    c_clear: cover property ($fell(detect_irq_flag));
    c_window: cover property (sample_time_up);
endmodule
bind card_detect_threshold_regs card_detect_regs_monitor u_mon (.*);

// ===== verif/card_detect_threshold_regs_tb_top.sv
// testbench for the card detection register block
// assumes the register map header and a 10 MHz clock
`timescale 1ns/1ps
`include "card_detect_map.vh"
module card_detect_threshold_regs_tb_top;
    logic aclk = 0, aresetn = 0, meas_start = 0, meas_done = 0, i_changed = 0, q_changed = 0;
    logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, detect_irq_flag, full_drive_during_detect, noise_filter_enable;
    logic sample_time_up;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] meas_i = 0, meas_q = 0;
    logic [7:0] ci [7] = '{8'h36, 8'h37, 8'h20, 8'h20, 8'h0b, 8'h0c, 8'h20};
    logic [7:0] cq [7] = '{8'h07, 8'h07, 8'h0b, 8'h04, 8'h07, 8'h05, 8'h0a};
    logic cf [7] = '{0, 1, 1, 1, 1, 0, 0};
    int miscompares = 0, checked = 0, cycles = 0, n;
    card_detect_threshold_regs dut (.*);
    initial forever #50 aclk = ~aclk;
    ////////////////////////////////////////
    // hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("Error %0t timeout", $time);
            conclude();
        end
    end
    task conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask
    ////////////////////////////////////////
    // bus cycles and measurement strobes
    task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awready) begin aw_ok = 1; s_axi_awvalid <= 0; end
            if (s_axi_wready) begin w_ok = 1; s_axi_wvalid <= 0; end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 0;
        cmp_word({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 0;
        cmp_word(s_axi_rdata, exp);
        cmp_word({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task meas(input logic [5:0] i, input logic [5:0] q, input logic ic, input logic qc);
        @(posedge aclk);
        {meas_i, meas_q, i_changed, q_changed, meas_done} <= {i, q, ic, qc, 1'b1};
        @(posedge aclk);
        meas_done <= 0;
        @(negedge aclk);
    endtask
    task start();
        @(posedge aclk);
        meas_start <= 1;
        @(posedge aclk);
        meas_start <= 0;
    endtask
    ////////////////////////////////////////
    // scenarios
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        rd(`IDX_Q_UPPER, 0, `RESP_OKAY);
        rd(`IDX_DETECT_OPTIONS, 0, `RESP_OKAY);
        rd(8'h44, 0, `RESP_SLVERR);
        wr(8'h44, 8'h55, `RESP_SLVERR);
        wr(`IDX_Q_LOWER, 8'hc5, `RESP_OKAY);
        wr(`IDX_Q_UPPER, 8'h4a, `RESP_OKAY);
        wr(`IDX_I_LOWER, 8'h8c, `RESP_OKAY);
        rd(`IDX_Q_LOWER, 8'hc5, `RESP_OKAY);
        rd(`IDX_Q_UPPER, 8'h4a, `RESP_OKAY);
        rd(`IDX_I_LOWER, 8'h8c, `RESP_OKAY);
        $display("test registers done");
        for (int k = 0; k < 7; k++) begin
            wr(`IDX_Q_RESULT, 8'h40, `RESP_OKAY);
            start();
            cmp_bit(detect_irq_flag, 0);
            meas(ci[k][5:0], cq[k][5:0], 0, 0);
            cmp_bit(detect_irq_flag, cf[k]);
            rd(`IDX_I_RESULT, {24'h0, ci[k]}, `RESP_OKAY);
            rd(`IDX_Q_RESULT, {24'h0, cq[k]}, `RESP_OKAY);
        end
        $display("test thresholds done");
        wr(`IDX_Q_RESULT, 8'h40, `RESP_OKAY);
        cmp_bit(detect_irq_flag, 0);
        meas(6'h3f, 6'h07, 0, 0);
        cmp_bit(detect_irq_flag, 0);
        rd(`IDX_Q_RESULT, 8'h47, `RESP_OKAY);
        wr(`IDX_I_RESULT, 8'hff, `RESP_OKAY);
        rd(`IDX_I_RESULT, 8'h3f, `RESP_OKAY);
        start();
        rd(`IDX_Q_RESULT, 8'h07, `RESP_OKAY);
        $display("test suppress done");
        wr(`IDX_DETECT_OPTIONS, 8'h0f, `RESP_OKAY);
        cmp_bit(full_drive_during_detect, 1);
        cmp_bit(noise_filter_enable, 1);
        rd(`IDX_DETECT_OPTIONS, 8'h0c, `RESP_OKAY);
        meas(6'h10, 6'h07, 1, 0);
        rd(`IDX_DETECT_OPTIONS, 8'h0d, `RESP_OKAY);
        meas(6'h10, 6'h07, 0, 1);
        rd(`IDX_DETECT_OPTIONS, 8'h0e, `RESP_OKAY);
        wr(`IDX_DETECT_OPTIONS, 8'h08, `RESP_OKAY);
        meas(6'h10, 6'h07, 1, 1);
        rd(`IDX_DETECT_OPTIONS, 8'h08, `RESP_OKAY);
        cmp_bit(noise_filter_enable, 0);
        $display("test options done");
        start();
        n = 0;
        while (n < 60 && sample_time_up !== 1'b1) begin
            @(posedge aclk);
            n++;
        end
        cmp_word(n, `SAMPLE_CYCLES);
        $display("test window done");
        conclude();
    end
endmodule
